// [rtl/readout_pkg.sv]
/*
  constants, register offsets and carrier types for the readout status and event generator.
  assumes a single 40 MHz clock and a byte-addressed register port behind base address zero.
*/
package readout_pkg;

  // register offsets (byte addresses within base address zero)
  localparam logic [11:0] OFF_DESCRIPTOR  = 12'h008;
  localparam logic [11:0] OFF_TRIGGER     = 12'h048;
  localparam logic [11:0] OFF_FREE_SEG    = 12'h04c;
  localparam logic [11:0] OFF_PENDING     = 12'h050;
  localparam logic [11:0] OFF_SPY_DEBUG   = 12'h054;
  localparam logic [11:0] OFF_PKT_SIZE    = 12'h080;
  localparam logic [11:0] OFF_HDR_SIZE    = 12'h084;
  localparam logic [11:0] OFF_SPIED_LOAD  = 12'h088;
  localparam logic [11:0] OFF_DBG_LOW     = 12'h100;
  localparam logic [11:0] OFF_DBG_HIGH    = 12'h104;
  localparam logic [11:0] OFF_DBG_CTRL    = 12'h108;
  localparam logic [11:0] OFF_DBG_RSVD    = 12'h10c;
  localparam logic [11:0] OFF_FIFO_STATUS = 12'h110;
  localparam logic [11:0] OFF_TIMER_LOW   = 12'h120;
  localparam logic [11:0] OFF_TIMER_HIGH  = 12'h124;
  localparam logic [11:0] OFF_EVT_LOW     = 12'h128;
  localparam logic [11:0] OFF_EVT_HIGH    = 12'h12c;

  // field positions
  localparam int PKT_SIZE_LSB  = 3;
  localparam int PKT_SIZE_MSB  = 15;
  localparam int HDR_SIZE_MSB  = 4;
  localparam int DESC_LOW_MSB  = 23;
  localparam int DESC_HIGH_LSB = 24;

  // values after reset
  localparam logic [12:0] PKT_SIZE_RESET = 13'h0000;
  localparam logic [4:0]  HDR_SIZE_RESET = 5'h06;

  // payload recurrence factors
  localparam logic [7:0] PRNG_MUL = 8'h05;
  localparam logic [7:0] PRNG_ADD = 8'h03;

  // least event length: header plus trailer
  localparam logic [23:0] MIN_EVT_LEN = 24'h000002;
  localparam logic [13:0] WORD_BYTES  = 14'h0008;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0]  source;
    logic [23:0] length;
    logic [7:0]  seed;
    logic [23:0] number;
  } gen_desc_t;

  typedef struct packed {
    logic [63:0] data;
    logic        ctrl;
  } link_word_t;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_HEAD = 2'b01,
    GEN_BODY = 2'b10,
    GEN_TAIL = 2'b11
  } gen_state_t;

endpackage : readout_pkg

// [rtl/readout_status_gen.sv]
/*
  register file and internal event generator of the readout link.
  assumes requests on the register port are single-cycle strobes, synchronous to clk_i,
  and that the network side takes one 64-bit word per cycle while evt_ready_i is high.
*/
`timescale 1ns/100ps
`default_nettype none

module readout_status_gen #(
  parameter int PARAM_DEPTH_LOG2 = 4,
  parameter int SPY_DEPTH_LOG2   = 10
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire readout_pkg::reg_req_t reg_req_i,
  output logic [31:0]                reg_rdata_o,
  output logic                       reg_rvalid_o,
  input  wire logic                  debug_mode_i,
  input  wire readout_pkg::link_word_t link_word_i,
  input  wire logic [8:0]            free_segment_count_i,
  input  wire logic [31:0]           spy_debug_word_i,
  output logic                       spy_debug_pop_o,
  input  wire logic [31:0]           fifo_status_word_i,
  output logic                       fifo_status_pop_o,
  output logic [23:0]                spied_event_o,
  output logic                       spied_valid_o,
  input  wire logic                  spied_pop_i,
  output logic [12:0]                packet_size_o,
  output logic [4:0]                 header_size_o,
  output logic [63:0]                evt_data_o,
  output logic                       evt_ctrl_o,
  output logic                       evt_valid_o,
  output logic                       evt_seg_end_o,
  input  wire logic                  evt_ready_i
);

  localparam int PD = 1 << PARAM_DEPTH_LOG2;
  localparam int SD = 1 << SPY_DEPTH_LOG2;

  function automatic logic [7:0] next_byte(input logic [7:0] b);
    logic [15:0] prod;
    prod = 16'(b) * 16'(readout_pkg::PRNG_MUL) + 16'(readout_pkg::PRNG_ADD);
    return prod[7:0];
  endfunction : next_byte

  logic                       wr_hit;
  logic                       rd_hit;
  logic [11:0]                addr;
  logic [31:0]                wdata;
  logic [12:0]                packet_size;
  logic [4:0]                 header_size;
  logic                       desc_second;
  logic [31:0]                desc_first;
  readout_pkg::gen_desc_t     param_mem [PD];
  logic [PARAM_DEPTH_LOG2:0]  param_wr;
  logic [PARAM_DEPTH_LOG2:0]  param_rd;
  logic [PARAM_DEPTH_LOG2:0]  param_count;
  logic                       param_full;
  logic [23:0]                spy_mem [SD];
  logic [SPY_DEPTH_LOG2:0]    spy_wr;
  logic [SPY_DEPTH_LOG2:0]    spy_rd;
  logic                       spy_full;
  readout_pkg::gen_state_t    state;
  readout_pkg::gen_desc_t     cur;
  logic [23:0]                remaining;
  logic [7:0]                 pay_byte;
  logic [31:0]                trigger_number;
  logic [63:0]                event_count;
  logic [15:0]                seg_bytes;
  logic                       fire;
  logic [31:0]                next_rdata;

  assign wr_hit = reg_req_i.wr;
  assign rd_hit = reg_req_i.rd;
  assign addr   = reg_req_i.addr;
  assign wdata  = reg_req_i.wdata;

  assign param_count = param_wr - param_rd;
  assign param_full  = param_count[PARAM_DEPTH_LOG2];
  assign spy_full    = (spy_wr[SPY_DEPTH_LOG2] != spy_rd[SPY_DEPTH_LOG2]) &&
                       (spy_wr[SPY_DEPTH_LOG2-1:0] == spy_rd[SPY_DEPTH_LOG2-1:0]);

  assign packet_size_o = packet_size;
  assign header_size_o = header_size;

  // configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      packet_size <= readout_pkg::PKT_SIZE_RESET;
      header_size <= readout_pkg::HDR_SIZE_RESET;
    end
    else if (wr_hit)
    begin
      if (addr == readout_pkg::OFF_PKT_SIZE)
        packet_size <= wdata[readout_pkg::PKT_SIZE_MSB:readout_pkg::PKT_SIZE_LSB];
      if (addr == readout_pkg::OFF_HDR_SIZE)
        header_size <= wdata[readout_pkg::HDR_SIZE_MSB:0];
    end
  end

  // descriptor pairing; a pair arriving while the fifo is full is dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      desc_second <= 1'b0;
      desc_first  <= 32'h0000_0000;
      param_wr    <= '0;
    end
    else if (wr_hit && addr == readout_pkg::OFF_DESCRIPTOR)
    begin
      if (!desc_second)
      begin
        desc_first  <= wdata;
        desc_second <= 1'b1;
      end
      else
      begin
        desc_second <= 1'b0;
        if (!param_full)
        begin
          param_mem[param_wr[PARAM_DEPTH_LOG2-1:0]] <= '{
            source: desc_first[31:readout_pkg::DESC_HIGH_LSB],
            length: desc_first[readout_pkg::DESC_LOW_MSB:0],
            seed:   wdata[31:readout_pkg::DESC_HIGH_LSB],
            number: wdata[readout_pkg::DESC_LOW_MSB:0]};
          param_wr <= param_wr + 1'b1;
        end
      end
    end
  end

  // spied event number queue
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      spy_wr <= '0;
    else if (wr_hit && addr == readout_pkg::OFF_SPIED_LOAD && !spy_full)
    begin
      spy_mem[spy_wr[SPY_DEPTH_LOG2-1:0]] <= wdata[23:0];
      spy_wr <= spy_wr + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      spy_rd <= '0;
    else if (spied_pop_i && spied_valid_o)
      spy_rd <= spy_rd + 1'b1;
  end

  assign spied_valid_o = (spy_wr != spy_rd);
  assign spied_event_o = spy_mem[spy_rd[SPY_DEPTH_LOG2-1:0]];

  // event generator
  assign fire        = evt_valid_o && evt_ready_i;
  assign evt_valid_o = (state != readout_pkg::GEN_IDLE);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state          <= readout_pkg::GEN_IDLE;
      cur            <= '0;
      remaining      <= 24'h000000;
      pay_byte       <= 8'h00;
      evt_data_o     <= 64'h0000_0000_0000_0000;
      evt_ctrl_o     <= 1'b0;
      param_rd       <= '0;
      trigger_number <= 32'h0000_0000;
      event_count    <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      case (state)
        readout_pkg::GEN_IDLE:
        begin
          if (param_count != '0)
          begin
            cur <= param_mem[param_rd[PARAM_DEPTH_LOG2-1:0]];
            if (param_mem[param_rd[PARAM_DEPTH_LOG2-1:0]].length < readout_pkg::MIN_EVT_LEN)
              remaining <= 24'h000000;
            else
              remaining <= param_mem[param_rd[PARAM_DEPTH_LOG2-1:0]].length - readout_pkg::MIN_EVT_LEN;
            pay_byte <= next_byte(param_mem[param_rd[PARAM_DEPTH_LOG2-1:0]].seed);
            evt_data_o <= {8'h00, param_mem[param_rd[PARAM_DEPTH_LOG2-1:0]].number,
                           param_mem[param_rd[PARAM_DEPTH_LOG2-1:0]].source,
                           param_mem[param_rd[PARAM_DEPTH_LOG2-1:0]].length};
            evt_ctrl_o <= 1'b1;
            trigger_number <= {8'h00, param_mem[param_rd[PARAM_DEPTH_LOG2-1:0]].number};
            state <= readout_pkg::GEN_HEAD;
          end
        end
        readout_pkg::GEN_HEAD, readout_pkg::GEN_BODY:
        begin
          if (fire)
          begin
            if (remaining == 24'h000000)
            begin
              evt_data_o <= {32'h0000_0000, cur.source, cur.length};
              evt_ctrl_o <= 1'b1;
              state      <= readout_pkg::GEN_TAIL;
            end
            else
            begin
              evt_data_o <= {8{pay_byte}};
              evt_ctrl_o <= 1'b0;
              pay_byte   <= next_byte(pay_byte);
              remaining  <= remaining - 24'h000001;
              state      <= readout_pkg::GEN_BODY;
            end
          end
        end
        readout_pkg::GEN_TAIL:
        begin
          if (fire)
          begin
            param_rd    <= param_rd + 1'b1;
            event_count <= event_count + 64'h0000_0000_0000_0001;
            evt_ctrl_o  <= 1'b0;
            state       <= readout_pkg::GEN_IDLE;
          end
        end
        default:
          state <= readout_pkg::GEN_IDLE;
      endcase
    end
  end

  // segmentation: a segment closes when it reaches the packet size or the event ends
  // the size field counts 64-bit words, so it is compared in bytes
  assign evt_seg_end_o = evt_valid_o &&
                         ((seg_bytes + 16'(readout_pkg::WORD_BYTES) >= {packet_size, 3'b000}) ||
                          state == readout_pkg::GEN_TAIL);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      seg_bytes <= 16'h0000;
    else if (fire)
      seg_bytes <= evt_seg_end_o ? 16'h0000 : seg_bytes + 16'(readout_pkg::WORD_BYTES);
  end

  // read mux; debug slots show zero outside word-by-word mode
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (addr)
      readout_pkg::OFF_TRIGGER:     next_rdata = trigger_number;
      readout_pkg::OFF_FREE_SEG:    next_rdata = {23'h000000, free_segment_count_i};
      readout_pkg::OFF_PENDING:     next_rdata = 32'(param_count);
      readout_pkg::OFF_SPY_DEBUG:   next_rdata = spy_debug_word_i;
      readout_pkg::OFF_PKT_SIZE:    next_rdata = {16'h0000, packet_size, 3'h0};
      readout_pkg::OFF_HDR_SIZE:    next_rdata = {27'h0000000, header_size};
      readout_pkg::OFF_DBG_LOW:     next_rdata = debug_mode_i ? link_word_i.data[31:0] : 32'h0000_0000;
      readout_pkg::OFF_DBG_HIGH:    next_rdata = debug_mode_i ? link_word_i.data[63:32] : 32'h0000_0000;
      readout_pkg::OFF_DBG_CTRL:    next_rdata = {31'h00000000, debug_mode_i & link_word_i.ctrl};
      readout_pkg::OFF_DBG_RSVD:    next_rdata = 32'h0000_0000;
      readout_pkg::OFF_FIFO_STATUS: next_rdata = fifo_status_word_i;
      readout_pkg::OFF_TIMER_LOW:   next_rdata = 32'h0000_0000;
      readout_pkg::OFF_TIMER_HIGH:  next_rdata = 32'h0000_0000;
      readout_pkg::OFF_EVT_LOW:     next_rdata = event_count[31:0];
      readout_pkg::OFF_EVT_HIGH:    next_rdata = event_count[63:32];
      default:                      next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o  <= 32'h0000_0000;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= rd_hit;
      if (rd_hit)
        reg_rdata_o <= next_rdata;
    end
  end

  // pops to the outside fifos fire with the read so the next word is ready in advance
  assign spy_debug_pop_o   = rd_hit && addr == readout_pkg::OFF_SPY_DEBUG;
  assign fifo_status_pop_o = rd_hit && addr == readout_pkg::OFF_FIFO_STATUS;

endmodule : readout_status_gen

`default_nettype wire

// [test/readout_props.sv]
/*
  concurrent checks on the register port and event stream of readout_status_gen.
  assumes it is bound to that module and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module readout_props (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire readout_pkg::reg_req_t   reg_req_i,
  input wire logic [31:0]             reg_rdata_o,
  input wire logic                    reg_rvalid_o,
  input wire logic                    spy_debug_pop_o,
  input wire logic                    fifo_status_pop_o,
  input wire logic                    debug_mode_i,
  input wire readout_pkg::link_word_t link_word_i,
  input wire logic [8:0]              free_segment_count_i,
  input wire logic [31:0]             spy_debug_word_i,
  input wire logic [31:0]             fifo_status_word_i,
  input wire logic [4:0]              header_size_o,
  input wire logic [63:0]             evt_data_o,
  input wire logic                    evt_ctrl_o,
  input wire logic                    evt_valid_o,
  input wire logic                    evt_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        rd;
  logic [11:0] ad;
  assign rd = reg_req_i.rd;
  assign ad = reg_req_i.addr;

  free_seg_a: assert property (
    rd && ad == readout_pkg::OFF_FREE_SEG |=> reg_rdata_o == {23'h0, $past(free_segment_count_i)})
    else $error("free segment read mismatch");
  spy_data_a: assert property (
    rd && ad == readout_pkg::OFF_SPY_DEBUG |=> reg_rdata_o == $past(spy_debug_word_i))
    else $error("spy fifo read mismatch");
  spy_pop_a: assert property (
    rd && ad == readout_pkg::OFF_SPY_DEBUG |-> spy_debug_pop_o)
    else $error("spy fifo not popped on read");
  status_pop_a: assert property (
    rd && ad == readout_pkg::OFF_FIFO_STATUS |-> fifo_status_pop_o)
    else $error("status fifo not popped on read");
  read_valid_a: assert property (
    rd |=> reg_rvalid_o)
    else $error("read answer missing");
  status_word_a: assert property (
    rd && ad == readout_pkg::OFF_FIFO_STATUS |=> reg_rdata_o == $past(fifo_status_word_i))
    else $error("status fifo read mismatch");
  debug_low_a: assert property (
    rd && debug_mode_i && ad == readout_pkg::OFF_DBG_LOW |=> reg_rdata_o == $past(link_word_i.data[31:0]))
    else $error("debug low word mismatch");
  debug_high_a: assert property (
    rd && debug_mode_i && ad == readout_pkg::OFF_DBG_HIGH |=> reg_rdata_o == $past(link_word_i.data[63:32]))
    else $error("debug high word mismatch");
  debug_flag_a: assert property (
    rd && debug_mode_i && ad == readout_pkg::OFF_DBG_CTRL |=> reg_rdata_o == {31'h0, $past(link_word_i.ctrl)})
    else $error("debug control flag mismatch");
  timer_zero_a: assert property (
    rd && (ad == readout_pkg::OFF_TIMER_LOW || ad == readout_pkg::OFF_TIMER_HIGH) |=> reg_rdata_o == 32'h0)
    else $error("timer read not zero");
  header_reset_a: assert property (
    $fell(rst_i) |-> header_size_o == 5'h06)
    else $error("header size not six after reset");
  lane_copy_a: assert property (
    evt_valid_o && !evt_ctrl_o |-> evt_data_o == {8{evt_data_o[7:0]}})
    else $error("payload lanes differ");
  byte_step_a: assert property (
    evt_valid_o && evt_ready_i && !evt_ctrl_o |=>
      !evt_valid_o || evt_ctrl_o || evt_data_o[7:0] == 8'($past(evt_data_o[7:0]) * 8'h05 + 8'h03))
    else $error("payload byte step wrong");
endmodule : readout_props

bind readout_status_gen readout_props u_props (.clk_i, .rst_i, .reg_req_i, .reg_rdata_o, .reg_rvalid_o,
  .spy_debug_pop_o, .fifo_status_pop_o, .debug_mode_i,
  .link_word_i, .free_segment_count_i, .spy_debug_word_i, .fifo_status_word_i, .header_size_o, .evt_data_o,
  .evt_ctrl_o, .evt_valid_o, .evt_ready_i);

`default_nettype wire

// [test/readout_sink_model.sv]
/*
  network side sink for the generated event stream.
  assumes one clock shared with the design; stalls one cycle in four so holds get exercised.
*/
`timescale 1ns/100ps
`default_nettype none

module readout_sink_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  output logic      evt_ready_o
);
  logic [1:0] phase;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end
  // a busy card drops ready now and then, never kinder than that
  assign evt_ready_o = enable_i && (phase != 2'h3);
endmodule : readout_sink_model

`default_nettype wire

// [test/tb.sv]
/*
  testbench for readout_status_gen: register calls plus event stream capture.
  assumes a 40 MHz clock and the sink model on the event side.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic                    clk_i, rst_i, debug_mode_i, spied_pop_i, run, reg_rvalid_o, spy_debug_pop_o;
  logic                    fifo_status_pop_o, spied_valid_o, evt_ctrl_o, evt_valid_o, evt_seg_end_o, evt_ready_i;
  readout_pkg::reg_req_t   reg_req_i;
  readout_pkg::link_word_t link_word_i;
  logic [8:0]              free_segment_count_i;
  logic [31:0]             spy_debug_word_i, fifo_status_word_i, reg_rdata_o;
  logic [23:0]             spied_event_o;
  logic [12:0]             packet_size_o;
  logic [4:0]              header_size_o;
  logic [63:0]             evt_data_o;
  logic [64:0]             words[$], exp_q[$];
  logic                    seg_q[$];
  logic [6:0]              exp_seg;
  int                      err_total, cmp_count, n;

  readout_status_gen #(.SPY_DEPTH_LOG2(3)) dut (.clk_i, .rst_i, .reg_req_i, .reg_rdata_o, .reg_rvalid_o,
    .debug_mode_i, .link_word_i, .free_segment_count_i, .spy_debug_word_i, .spy_debug_pop_o, .fifo_status_word_i,
    .fifo_status_pop_o, .spied_event_o, .spied_valid_o, .spied_pop_i, .packet_size_o, .header_size_o,
    .evt_data_o, .evt_ctrl_o, .evt_valid_o, .evt_seg_end_o, .evt_ready_i);
  readout_sink_model sink (.clk_i, .rst_i, .enable_i(run), .evt_ready_o(evt_ready_i));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (evt_valid_o === 1'b1 && evt_ready_i === 1'b1)
    begin
      words.push_back({evt_ctrl_o, evt_data_o});
      seg_q.push_back(evt_seg_end_o);
    end

  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [64:0] seen, input logic [64:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask : step
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    step;
    reg_req_i = {2'b10, a, d};
    step;
    reg_req_i = '0;
  endtask : reg_wr
  // rvalid is due at once; the loop only guards against a hang
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] e, input string what);
    int k;
    step;
    reg_req_i = {2'b01, a, 32'h0};
    step;
    reg_req_i = '0;
    k = 0;
    while (reg_rvalid_o !== 1'b1 && k < 4)
    begin
      step;
      k++;
    end
    check(what, {33'h0, reg_rdata_o}, {33'h0, e});
  endtask : reg_rd
  task automatic add_evt(input logic [7:0] src, input logic [23:0] len, input logic [23:0] num, input logic [7:0] b);
    exp_q.push_back({1'b1, 8'h00, num, src, len});
    repeat (int'(len) - 2)
    begin
      b = b * 8'h05 + 8'h03;
      exp_q.push_back({1'b0, {8{b}}});
    end
    exp_q.push_back({1'b1, 32'h0, src, len});
  endtask : add_evt

  initial
  begin
    reg_req_i = '0;
    rst_i = 1'b1;
    {debug_mode_i, spied_pop_i, run} = 3'h0;
    link_word_i = {64'h89ab_cdef_0123_4567, 1'b1};
    free_segment_count_i = 9'h1a5;
    spy_debug_word_i = 32'h8000_1234;
    fifo_status_word_i = 32'h5a5a_0f0f;
    err_total = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk_i);
    #1 rst_i = 1'b0;
    reg_rd(readout_pkg::OFF_PKT_SIZE, 32'h0, "packet size reset");
    reg_rd(readout_pkg::OFF_HDR_SIZE, 32'h6, "header size reset");
    reg_rd(readout_pkg::OFF_TIMER_HIGH, 32'h0, "timer high");
    reg_rd(12'h1f0, 32'h0, "unmapped");
    reg_wr(readout_pkg::OFF_PKT_SIZE, 32'h0000_0040);
    reg_rd(readout_pkg::OFF_PKT_SIZE, 32'h40, "packet size");
    check("packet size pin", {52'h0, packet_size_o}, 65'h8);
    reg_wr(readout_pkg::OFF_HDR_SIZE, 32'hffff_ffff);
    reg_rd(readout_pkg::OFF_HDR_SIZE, 32'h1f, "header size");
    reg_wr(readout_pkg::OFF_FREE_SEG, 32'h0);
    reg_rd(readout_pkg::OFF_FREE_SEG, 32'h1a5, "free segments");
    reg_rd(readout_pkg::OFF_SPY_DEBUG, 32'h8000_1234, "spy word");
    reg_rd(readout_pkg::OFF_FIFO_STATUS, 32'h5a5a_0f0f, "status word");
    debug_mode_i = 1'b1;
    reg_rd(readout_pkg::OFF_DBG_LOW, 32'h0123_4567, "debug low");
    reg_rd(readout_pkg::OFF_DBG_HIGH, 32'h89ab_cdef, "debug high");
    reg_rd(readout_pkg::OFF_DBG_CTRL, 32'h1, "debug flag");
    debug_mode_i = 1'b0;
    reg_rd(readout_pkg::OFF_DBG_LOW, 32'h0, "debug off");
    for (int i = 0; i < 9; i++)
      reg_wr(readout_pkg::OFF_SPIED_LOAD, 32'hff00_0100 + i);
    for (int i = 0; i < 8; i++)
    begin
      check("spied valid", {64'h0, spied_valid_o}, 65'h1);
      check("spied head", {41'h0, spied_event_o}, 65'h100 + i);
      step;
      spied_pop_i = 1'b1;
      step;
      spied_pop_i = 1'b0;
    end
    check("spied drained", {64'h0, spied_valid_o}, 65'h0);
    reg_wr(readout_pkg::OFF_PKT_SIZE, 32'h0000_0010);
    exp_seg = 7'b1101010;
    reg_wr(readout_pkg::OFF_DESCRIPTOR, {8'h5a, 24'h000004});
    reg_rd(readout_pkg::OFF_PENDING, 32'h0, "odd descriptor");
    reg_wr(readout_pkg::OFF_DESCRIPTOR, {8'h11, 24'h000123});
    reg_wr(readout_pkg::OFF_DESCRIPTOR, {8'h77, 24'h000003});
    reg_wr(readout_pkg::OFF_DESCRIPTOR, {8'hff, 24'h000200});
    reg_rd(readout_pkg::OFF_PENDING, 32'h2, "pending");
    add_evt(8'h5a, 24'h000004, 24'h000123, 8'h11);
    add_evt(8'h77, 24'h000003, 24'h000200, 8'hff);
    run = 1'b1;
    n = 0;
    while (words.size() < exp_q.size() && n < 200)
    begin
      step;
      n++;
    end
    check("stream done", {64'h0, words.size() == exp_q.size()}, 65'h1);
    for (int i = 0; i < exp_q.size() && i < words.size(); i++)
      check("event word", words[i], exp_q[i]);
    for (int i = 0; i < 7 && i < seg_q.size(); i++)
      check("segment end", {64'h0, seg_q[i]}, {64'h0, exp_seg[i]});
    repeat (4) step;
    reg_rd(readout_pkg::OFF_PENDING, 32'h0, "pending drained");
    reg_rd(readout_pkg::OFF_EVT_LOW, 32'h2, "event count low");
    reg_rd(readout_pkg::OFF_EVT_HIGH, 32'h0, "event count high");
    reg_rd(readout_pkg::OFF_TRIGGER, 32'h200, "trigger number");
    rst_i = 1'b1;
    repeat (2) step;
    rst_i = 1'b0;
    reg_rd(readout_pkg::OFF_HDR_SIZE, 32'h6, "header after reset");
    reg_rd(readout_pkg::OFF_EVT_LOW, 32'h0, "count after reset");
    wrap_up;
  end
endmodule : tb

`default_nettype wire
